// ===== pkg/gpio_ef_pkg.sv
package gpio_ef_pkg;
  // register byte addresses on the bus
  localparam logic [11:0] port_e_data_latch_off = 12'h000;
  localparam logic [11:0] port_e_direction_off = 12'h004;
  localparam logic [11:0] port_f_data_latch_off = 12'h008;
  localparam logic [11:0] port_f_direction_off = 12'h00c;
  // widths and reset values
  localparam int port_width = 8;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic [7:0] direction_reset = 8'h00;
  // position of the input-only pin on port e
  localparam int port_e_input_only_pin = 1;
  // mask of bits that can really drive a port e pin
  localparam logic [7:0] port_e_drive_mask = 8'hfd;

  // one port's pin-facing signals
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_b;
  } pin_drive_s;
endpackage

// ===== rtl/dual_parallel_io_port.sv
// Overview of operation
// - input pins read back their live level
// - output pins read back the written latch
// - data writes update all eight latch bits
// - output pins driven from their latch bits
// - reset clears both data latches
// - reset leaves every pin undriven input
// - direction zero disables driver, reads pin
// - direction one enables driver, reads latch
// - port e bit one always reads pin
// - port e pin one never driven
// - port f has eight independent direction bits
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dual_parallel_io_port (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [7:0] port_e_pin_in,
  input wire logic [7:0] port_f_pin_in,
  output gpio_ef_pkg::pin_drive_s port_e_pins_out,
  output gpio_ef_pkg::pin_drive_s port_f_pins_out
);
  import gpio_ef_pkg::*;

  logic rst_meta_b_reg;
  logic rst_sync_b_reg;
  logic [7:0] e_meta_reg;
  logic [7:0] e_sync_reg;
  logic [7:0] f_meta_reg;
  logic [7:0] f_sync_reg;
  logic [7:0] e_latch_reg;
  logic [7:0] e_latch_next;
  logic [7:0] e_dir_reg;
  logic [7:0] e_dir_next;
  logic [7:0] f_latch_reg;
  logic [7:0] f_latch_next;
  logic [7:0] f_dir_reg;
  logic [7:0] f_dir_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic access;
  logic setup;
  logic wr_en;
  logic hit;
  logic [3:0] reg_sel;
  logic sel_e_data;
  logic sel_e_dir;
  logic sel_f_data;
  logic sel_f_dir;
  logic wr_e_data;
  logic wr_e_dir;
  logic wr_f_data;
  logic wr_f_dir;
  logic [7:0] e_data_rd;
  logic [7:0] f_data_rd;
  pin_drive_s e_drive_reg;
  pin_drive_s e_drive_next;
  pin_drive_s f_drive_reg;
  pin_drive_s f_drive_next;

  // per-bit read source select: latch where driven, pin otherwise
  function automatic logic [7:0] read_mux(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
    read_mux = (dir & latch) | (~dir & pin);
  endfunction

  // apply a byte-lane-0 write to an 8-bit register
  function automatic logic [7:0] lane_write(input logic [7:0] cur,
                                            input logic sel);
    lane_write = (sel && pstrb_in[0]) ? pwdata_in[7:0] : cur;
  endfunction

  // port e read value: the input-only bit always shows its pin
  function automatic logic [7:0] port_e_read(input logic [7:0] dir,
                                             input logic [7:0] latch,
                                             input logic [7:0] pin);
    port_e_read = read_mux(dir, latch, pin);
    port_e_read[port_e_input_only_pin] =
      pin[port_e_input_only_pin];
  endfunction

  // one-hot register select from a byte address, zero when unmapped
  function automatic logic [3:0] reg_decode(input logic [11:0] addr);
    reg_decode = 4'h0;
    unique case (addr)
      port_e_data_latch_off: reg_decode = 4'h1;
      port_e_direction_off: reg_decode = 4'h2;
      port_f_data_latch_off: reg_decode = 4'h4;
      port_f_direction_off: reg_decode = 4'h8;
      default: reg_decode = 4'h0;
    endcase
  endfunction

  // reset release synchroniser
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_b_reg <= 1'b0;
      rst_sync_b_reg <= 1'b0;
    end else begin
      rst_meta_b_reg <= 1'b1;
      rst_sync_b_reg <= rst_meta_b_reg;
    end
  end

  // port e pin synchroniser; only the second stage is read
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      e_meta_reg <= 8'h00;
      e_sync_reg <= 8'h00;
    end else begin
      e_meta_reg <= port_e_pin_in;
      e_sync_reg <= e_meta_reg;
    end
  end

  // port f pin synchroniser; only the second stage is read
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      f_meta_reg <= 8'h00;
      f_sync_reg <= 8'h00;
    end else begin
      f_meta_reg <= port_f_pin_in;
      f_sync_reg <= f_meta_reg;
    end
  end

  // apb decode, zero wait states
  assign access = psel_in && penable_in;
  assign setup = psel_in && !penable_in;
  assign wr_en = access && pwrite_in;
  assign hit = |reg_sel;
  assign pready_out = 1'b1;

  // register selects for the addressed word
  assign reg_sel = reg_decode(paddr_in);
  assign sel_e_data = reg_sel[0];
  assign sel_e_dir = reg_sel[1];
  assign sel_f_data = reg_sel[2];
  assign sel_f_dir = reg_sel[3];

  // write strobes, one per register, access phase only
  assign wr_e_data = wr_en && sel_e_data;
  assign wr_e_dir = wr_en && sel_e_dir;
  assign wr_f_data = wr_en && sel_f_data;
  assign wr_f_dir = wr_en && sel_f_dir;

  // port e data latch: a write replaces all eight bits
  always_comb begin
    e_latch_next = lane_write(e_latch_reg, wr_e_data);
  end

  // port e data latch register
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      e_latch_reg <= latch_reset;
    end else begin
      e_latch_reg <= e_latch_next;
    end
  end

  // port e direction: the input-only bit is stored but never drives
  always_comb begin
    e_dir_next = lane_write(e_dir_reg, wr_e_dir);
  end

  // port e direction register; zero makes every pin an input
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      e_dir_reg <= direction_reset;
    end else begin
      e_dir_reg <= e_dir_next;
    end
  end

  // port f data latch: a write replaces all eight bits
  always_comb begin
    f_latch_next = lane_write(f_latch_reg, wr_f_data);
  end

  // port f data latch register
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      f_latch_reg <= latch_reset;
    end else begin
      f_latch_reg <= f_latch_next;
    end
  end

  // port f direction: eight independent bits
  always_comb begin
    f_dir_next = lane_write(f_dir_reg, wr_f_dir);
  end

  // port f direction register; zero makes every pin an input
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      f_dir_reg <= direction_reset;
    end else begin
      f_dir_reg <= f_dir_next;
    end
  end

  // read candidates for the two data registers
  assign e_data_rd = port_e_read(e_dir_reg, e_latch_reg,
                                 e_sync_reg);
  assign f_data_rd = read_mux(f_dir_reg, f_latch_reg,
                              f_sync_reg);

  // read data captured at setup, held until the next setup
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      if (!pwrite_in) begin
        unique case (paddr_in)
          port_e_data_latch_off: prdata_next[7:0] = e_data_rd;
          port_e_direction_off: prdata_next[7:0] = e_dir_reg;
          port_f_data_latch_off: prdata_next[7:0] = f_data_rd;
          port_f_direction_off: prdata_next[7:0] = f_dir_reg;
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // error response for unmapped words, decided at setup
  always_comb begin
    pslverr_next = 1'b0;
    if (setup) begin
      pslverr_next = !hit;
    end
  end

  // read data register
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // error flag register; the port gates it to the access phase
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  // bus outputs
  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg && access;

  // port e pin drive: latch level, enable low where driven
  always_comb begin
    e_drive_next.out = e_latch_next;
    e_drive_next.oe_b = ~(e_dir_next & port_e_drive_mask);
  end

  // port e drive register; reset leaves every pin undriven
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      e_drive_reg.out <= latch_reset;
      e_drive_reg.oe_b <= ~direction_reset;
    end else begin
      e_drive_reg <= e_drive_next;
    end
  end

  // port f pin drive: latch level, enable low where driven
  always_comb begin
    f_drive_next.out = f_latch_next;
    f_drive_next.oe_b = ~f_dir_next;
  end

  // port f drive register; reset leaves every pin undriven
  always_ff @(posedge sys_clk_in or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      f_drive_reg.out <= latch_reset;
      f_drive_reg.oe_b <= ~direction_reset;
    end else begin
      f_drive_reg <= f_drive_next;
    end
  end

  // registered pin drives leave the block
  assign port_e_pins_out = e_drive_reg;
  assign port_f_pins_out = f_drive_reg;
endmodule

// ===== verification/gpio_ef_checker.sv
`timescale 1ns/1ps
module gpio_ef_checker import gpio_ef_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic [3:0] pstrb_in,
  input wire pin_drive_s port_e_pins_out,
  input wire pin_drive_s port_f_pins_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // accepted write and read access phases
  wire logic wr = psel_in & penable_in & pwrite_in & pstrb_in[0];
  wire logic rd = psel_in & penable_in & !pwrite_in;
  property p_e1; port_e_pins_out.oe_b[1]; endproperty
  a_e1: assert property (p_e1) else $error("e pin 1 driven");
  property p_rst; $rose(rst_b_in) |-> &{port_e_pins_out.oe_b,
    port_f_pins_out.oe_b} && !{port_e_pins_out.out, port_f_pins_out.out};
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_edir; wr && paddr_in == port_e_direction_off |=>
    port_e_pins_out.oe_b == ~($past(pwdata_in[7:0]) & port_e_drive_mask);
  endproperty
  a_edir: assert property (p_edir) else $error("e dir");
  property p_fdir; wr && paddr_in == port_f_direction_off |=>
    port_f_pins_out.oe_b == ~$past(pwdata_in[7:0]); endproperty
  a_fdir: assert property (p_fdir) else $error("f dir");
  property p_edat; wr && paddr_in == port_e_data_latch_off |=>
    port_e_pins_out.out == $past(pwdata_in[7:0]); endproperty
  a_edat: assert property (p_edat) else $error("e out");
  property p_fdat; wr && paddr_in == port_f_data_latch_off |=>
    port_f_pins_out.out == $past(pwdata_in[7:0]); endproperty
  a_fdat: assert property (p_fdat) else $error("f out");
  property p_erd; rd && paddr_in == port_e_data_latch_off |->
    (prdata_out[7:0] | port_e_pins_out.oe_b) ==
    (port_e_pins_out.out | port_e_pins_out.oe_b); endproperty
  a_erd: assert property (p_erd) else $error("e read");
  property p_frd; rd && paddr_in == port_f_data_latch_off |->
    (prdata_out[7:0] | port_f_pins_out.oe_b) ==
    (port_f_pins_out.out | port_f_pins_out.oe_b); endproperty
  a_frd: assert property (p_frd) else $error("f read");
endmodule
bind dual_parallel_io_port gpio_ef_checker u_gpio_ef_checker (.*);

// ===== verification/pin_side_model.sv
`timescale 1ns/1ps
module pin_side_model import gpio_ef_pkg::*; (
  input wire pin_drive_s drive_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] pin_out
);
  // driven bits show the port, undriven bits the outside level
  assign pin_out = (drive_in.out & ~drive_in.oe_b) |
    (ext_in & drive_in.oe_b);
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import gpio_ef_pkg::*;
  logic sys_clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, pready_out, pslverr_out;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out;
  logic [3:0] pstrb_in = 0;
  logic [7:0] xe = 0, xf = 0, de, port_e_pin_in, port_f_pin_in;
  logic [7:0] m [4];
  logic [32:0] q [$];
  pin_drive_s port_e_pins_out, port_f_pins_out;
  int error_cnt = 0, samples_checked = 0;
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  dual_parallel_io_port u_dual_parallel_io_port (.*);
  pin_side_model u_pin_side_model_e (.drive_in(port_e_pins_out),
    .ext_in(xe), .pin_out(port_e_pin_in));
  pin_side_model u_pin_side_model_f (.drive_in(port_f_pins_out),
    .ext_in(xf), .pin_out(port_f_pin_in));
  task chk(input logic [32:0] s, input logic [32:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int i;
    @(posedge sys_clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} <=
      {2'b10, w, a, d, s};
    @(posedge sys_clk_in);
    penable_in <= 1;
    i = 0;
    do begin
      @(posedge sys_clk_in);
      i++;
    end while (pready_out !== 1'b1 && i < 20);
    {psel_in, penable_in} <= 2'b00;
    if (pready_out !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic err);
    q.push_back({err, 24'h0, e});
    apb(0, a, $urandom, 4'h0);
  endtask
  // random write; a clear strobe bit 0 leaves the register alone
  task wr(input logic [11:0] a);
    logic [31:0] d;
    logic [3:0] s;
    d = $urandom;
    s = $urandom;
    apb(1, a, d, s);
    if (s[0]) m[a[3:2]] = d[7:0];
  endtask
  task rd_all;
    de = m[1] & port_e_drive_mask;
    rd(port_e_data_latch_off, (m[0] & de) | (xe & ~de), 0);
    rd(port_e_direction_off, m[1], 0);
    rd(port_f_data_latch_off, (m[2] & m[3]) | (xf & ~m[3]), 0);
    rd(port_f_direction_off, m[3], 0);
  endtask
  task reset_dut;
    rst_b_in <= 0;
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    m = '{default: 8'h00};
  endtask
  // read results against the oldest expectation
  always @(posedge sys_clk_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out)
      chk({pslverr_out, prdata_out}, q.pop_front());
  end
  initial begin
    void'($urandom(2969));
    reset_dut();
    rd_all();
    $display("test reset values done");
    repeat (24) begin
      xe <= $urandom;
      xf <= $urandom;
      for (int a = 0; a < 16; a += 4) wr(12'(a));
      rd_all();
    end
    $display("test random traffic done");
    apb(1, 12'h010, $urandom, 4'hf);
    rd(12'h010, 8'h00, 1);
    rd_all();
    $display("test unmapped done");
    reset_dut();
    rd_all();
    $display("test second reset done");
    summarize();
  end
endmodule
